/* File: design/gidp_top.sv */
// Port banks reached through an index/data register pair, with pin setup and combined interrupt.
`timescale 1ns/1ps
`default_nettype none

module gidp_top #(
	parameter int DBNC_CYCLES = gidp_pkg::DBNC_CYCLES
) (
	// Clock and reset.
	input  wire logic                          clk_i,
	input  wire logic                          sys_rst_i,
	// Run-mode host port.
	input  wire gidp_pkg::gidp_io_req_t        io_req_i,
	output logic [7:0]                         io_rdata_o,
	output logic                               io_rvalid_o,
	// Configuration-mode port.
	input  wire gidp_pkg::gidp_cfg_req_t       cfg_req_i,
	output logic [7:0]                         cfg_rdata_o,
	output logic                               cfg_rvalid_o,
	input  wire logic                          run_access_en_i,
	// Pins.
	input  wire logic [gidp_pkg::NUM_PINS-1:0] pin_in_i,
	output logic [gidp_pkg::NUM_PINS-1:0]      pin_out_o,
	output logic [gidp_pkg::NUM_PINS-1:0]      pin_oe_n_o,
	// Alternate function signals.
	input  wire logic [gidp_pkg::NUM_PINS-1:0] alt_out_i,
	output logic [gidp_pkg::NUM_PINS-1:0]      alt_in_o,
	// Interrupt and register contents.
	output logic                               combined_port_interrupt_o,
	output logic [3:0]                         combined_irq_channel_select_o,
	output logic [7:0]                         watchdog_control_reg_o,
	output logic [gidp_pkg::SPM_REGS-1:0][7:0] spm_regs_o
);

	localparam int NP = gidp_pkg::NUM_PINS;
	localparam int BW = gidp_pkg::BANK_W;
	localparam int NB = gidp_pkg::NUM_BANKS;

	// Register state and next values.
	logic [1:0]                          base_sel;
	logic [7:0]                          port_select_index;
	logic [NB-1:0][BW-1:0]               bank;
	logic [gidp_pkg::SPM_REGS-1:0][7:0]  spm;
	gidp_pkg::gidp_pin_cfg_t [NP-1:0]    port_pin_setup;
	logic [7:0]                          wdt;
	logic [3:0]                          irq_chan;
	logic [1:0]                          next_base_sel;
	logic [7:0]                          next_port_select_index;
	logic [NB-1:0][BW-1:0]               next_bank;
	logic [gidp_pkg::SPM_REGS-1:0][7:0]  next_spm;
	gidp_pkg::gidp_pin_cfg_t [NP-1:0]    next_port_pin_setup;
	logic [7:0]                          next_wdt;
	logic [3:0]                          next_irq_chan;
	logic [7:0]                          next_io_rdata;
	logic                                next_io_rvalid;
	logic [7:0]                          next_cfg_rdata;
	logic                                next_cfg_rvalid;

	// Decode and pin cell results.
	logic [gidp_pkg::IO_ADDR_W-1:0]      index_addr;
	logic                                hit_idx;
	logic                                hit_dat;
	logic [7:0]                          acc_idx;
	logic                                acc_wr;
	logic [7:0]                          acc_wdata;
	logic [7:0]                          acc_rval;
	logic                                acc_is_bank;
	logic [2:0]                          acc_bank;
	logic [NP-1:0]                       cell_drive;
	logic [NP-1:0]                       cell_oe_n;
	logic [NP-1:0]                       cell_rd;
	logic [NP-1:0]                       cell_alt_in;
	logic [NP-1:0]                       cell_irq;
	logic [NP-1:0]                       dir_in_vec;

	// Maps a configuration register number onto the equivalent run-mode index.
	function automatic logic [7:0] cr_to_idx(input logic [7:0] regno);
		logic [7:0] idx;
		idx = 8'h00;
		if (regno == gidp_pkg::CR_WDT) begin
			idx = gidp_pkg::IDX_WDT;
		end else if (regno == gidp_pkg::CR_BANK1) begin
			idx = gidp_pkg::IDX_BANK1;
		end else if (regno == gidp_pkg::CR_BANK2) begin
			idx = gidp_pkg::IDX_BANK2;
		end else if (regno >= gidp_pkg::CR_BANK4 && regno <= gidp_pkg::CR_BANK7) begin
			idx = regno - gidp_pkg::CR_BANK4 + gidp_pkg::IDX_BANK4;
		end else if (regno >= gidp_pkg::CR_SPM_FIRST && regno <= gidp_pkg::CR_SPM_LAST) begin
			idx = regno - gidp_pkg::CR_SPM_FIRST + gidp_pkg::IDX_SPM_FIRST;
		end
		return idx;
	endfunction

	// ----------------------------------------------------------------
	// Pin cells
	// ----------------------------------------------------------------

	for (genvar p = 0; p < NP; p++) begin : g_pin
		assign dir_in_vec[p] = port_pin_setup[p].dir_in;
		gidp_pin_cell #(
			.DBNC_CYCLES (DBNC_CYCLES),
			.ALT_IN_TYPE (gidp_pkg::ALT_IN_TYPE_MASK[p])
		) u_cell (
			.clk_i      (clk_i),
			.sys_rst_i  (sys_rst_i),
			.pin_i      (pin_in_i[p]),
			.cfg_i      (port_pin_setup[p]),
			.data_bit_i (bank[p / BW][p % BW]),
			.alt_out_i  (alt_out_i[p]),
			.drive_o    (cell_drive[p]),
			.oe_n_o     (cell_oe_n[p]),
			.rd_bit_o   (cell_rd[p]),
			.alt_in_o   (cell_alt_in[p]),
			.irq_o      (cell_irq[p])
		);
	end

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------

	// Address match of the index/data pair and selection of the accessed register.
	always_comb begin
		case (base_sel)
			2'h0: index_addr = gidp_pkg::ADDR_IDX_E0;
			2'h1: index_addr = gidp_pkg::ADDR_IDX_E2;
			2'h2: index_addr = gidp_pkg::ADDR_IDX_E4;
			default: index_addr = gidp_pkg::ADDR_IDX_EA;
		endcase
		hit_idx = run_access_en_i && !cfg_req_i.mode && io_req_i.addr == index_addr;
		hit_dat = run_access_en_i && !cfg_req_i.mode
			&& io_req_i.addr == index_addr + gidp_pkg::DATA_OFFSET;
		if (cfg_req_i.mode) begin
			acc_idx   = cr_to_idx(cfg_req_i.regno);
			acc_wr    = cfg_req_i.wr;
			acc_wdata = cfg_req_i.wdata;
		end else begin
			acc_idx   = hit_dat ? port_select_index : 8'h00;
			acc_wr    = hit_dat && io_req_i.wr;
			acc_wdata = io_req_i.wdata;
		end
		acc_is_bank = (acc_idx == gidp_pkg::IDX_BANK1) || (acc_idx == gidp_pkg::IDX_BANK2)
			|| (acc_idx >= gidp_pkg::IDX_BANK4 && acc_idx <= gidp_pkg::IDX_BANK7);
		acc_bank = (acc_idx < gidp_pkg::IDX_WDT) ? 3'(acc_idx - 8'h01) : 3'(acc_idx - 8'h02);
	end

	// Read value of the selected register; unmapped codes read as zero.
	always_comb begin
		acc_rval = 8'h00;
		if (acc_is_bank) begin
			acc_rval = cell_rd[acc_bank * BW +: BW];
		end else if (acc_idx == gidp_pkg::IDX_WDT) begin
			acc_rval = wdt;
		end else if (acc_idx >= gidp_pkg::IDX_SPM_FIRST && acc_idx <= gidp_pkg::IDX_LAST) begin
			acc_rval = spm[3'(acc_idx - gidp_pkg::IDX_SPM_FIRST)];
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------

	// Next values of every register and of the read answers.
	always_comb begin
		next_base_sel          = base_sel;
		next_port_select_index = port_select_index;
		next_bank              = bank;
		next_spm               = spm;
		next_port_pin_setup    = port_pin_setup;
		next_wdt               = wdt;
		next_irq_chan          = irq_chan;
		next_io_rdata          = io_rdata_o;
		next_io_rvalid         = 1'b0;
		next_cfg_rdata         = cfg_rdata_o;
		next_cfg_rvalid        = 1'b0;
		if (hit_idx && io_req_i.wr) begin
			next_port_select_index = io_req_i.wdata;
		end
		if (acc_wr) begin
			if (acc_is_bank) begin
				next_bank[acc_bank] = (bank[acc_bank] & dir_in_vec[acc_bank * BW +: BW])
					| (acc_wdata & ~dir_in_vec[acc_bank * BW +: BW]);
			end else if (acc_idx == gidp_pkg::IDX_WDT) begin
				next_wdt = acc_wdata;
			end else if (acc_idx >= gidp_pkg::IDX_SPM_FIRST && acc_idx <= gidp_pkg::IDX_LAST) begin
				next_spm[3'(acc_idx - gidp_pkg::IDX_SPM_FIRST)] = acc_wdata;
			end
		end
		if (hit_idx && io_req_i.rd) begin
			next_io_rdata  = port_select_index;
			next_io_rvalid = 1'b1;
		end else if (hit_dat && io_req_i.rd) begin
			next_io_rdata  = acc_rval;
			next_io_rvalid = 1'b1;
		end
		if (cfg_req_i.mode && cfg_req_i.wr) begin
			if (cfg_req_i.regno <= gidp_pkg::CR_PIN_LAST) begin
				next_port_pin_setup[cfg_req_i.regno[5:0]] = gidp_pkg::gidp_pin_cfg_t'(cfg_req_i.wdata);
			end else if (cfg_req_i.regno == gidp_pkg::CR_INDEX_SEL) begin
				next_base_sel = cfg_req_i.wdata[1:0];
			end else if (cfg_req_i.regno == gidp_pkg::CR_IRQ_CHAN) begin
				next_irq_chan = cfg_req_i.wdata[3:0];
			end
		end
		if (cfg_req_i.mode && cfg_req_i.rd) begin
			next_cfg_rvalid = 1'b1;
			if (cfg_req_i.regno <= gidp_pkg::CR_PIN_LAST) begin
				next_cfg_rdata = port_pin_setup[cfg_req_i.regno[5:0]];
			end else if (cfg_req_i.regno == gidp_pkg::CR_INDEX_SEL) begin
				next_cfg_rdata = {6'h00, base_sel};
			end else if (cfg_req_i.regno == gidp_pkg::CR_IRQ_CHAN) begin
				next_cfg_rdata = {4'h0, irq_chan};
			end else begin
				next_cfg_rdata = acc_rval;
			end
		end
	end

	// Registers and registered outputs.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			base_sel                      <= gidp_pkg::BASE_SEL_RST;
			port_select_index             <= gidp_pkg::INDEX_RST;
			bank                          <= {NB{gidp_pkg::BANK_RST}};
			spm                           <= {gidp_pkg::SPM_REGS{gidp_pkg::SPM_RST}};
			port_pin_setup                <= {NP{gidp_pkg::PIN_CFG_RST}};
			wdt                           <= gidp_pkg::WDT_RST;
			irq_chan                      <= gidp_pkg::IRQ_CHAN_RST;
			io_rdata_o                    <= 8'h00;
			io_rvalid_o                   <= 1'b0;
			cfg_rdata_o                   <= 8'h00;
			cfg_rvalid_o                  <= 1'b0;
			pin_out_o                     <= '0;
			pin_oe_n_o                    <= '1;
			alt_in_o                      <= '0;
			combined_port_interrupt_o     <= 1'b0;
		end else begin
			base_sel                      <= next_base_sel;
			port_select_index             <= next_port_select_index;
			bank                          <= next_bank;
			spm                           <= next_spm;
			port_pin_setup                <= next_port_pin_setup;
			wdt                           <= next_wdt;
			irq_chan                      <= next_irq_chan;
			io_rdata_o                    <= next_io_rdata;
			io_rvalid_o                   <= next_io_rvalid;
			cfg_rdata_o                   <= next_cfg_rdata;
			cfg_rvalid_o                  <= next_cfg_rvalid;
			pin_out_o                     <= cell_drive;
			pin_oe_n_o                    <= cell_oe_n;
			alt_in_o                      <= cell_alt_in;
			combined_port_interrupt_o     <= |cell_irq;
		end
	end

	// Register contents presented to the rest of the chip.
	assign combined_irq_channel_select_o = irq_chan;
	assign watchdog_control_reg_o        = wdt;
	assign spm_regs_o                    = spm;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	a_index_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(hit_idx && io_req_i.wr) |=> (port_select_index == $past(io_req_i.wdata)))
		else $error("index write not taken");

	a_read_answer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(run_access_en_i && !cfg_req_i.mode && io_req_i.rd
			&& io_req_i.addr == index_addr + gidp_pkg::DATA_OFFSET) |=> io_rvalid_o)
		else $error("data port read not answered");

	a_run_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(io_req_i.rd && (!run_access_en_i || cfg_req_i.mode) && !(cfg_req_i.mode && cfg_req_i.rd))
			|=> !io_rvalid_o)
		else $error("run access answered while disabled");

	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(hit_dat && io_req_i.rd && (port_select_index == 8'h00 || port_select_index > 8'h0F))
			|=> (io_rdata_o == 8'h00))
		else $error("unmapped index read not zero");

	a_wdt_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(hit_dat && io_req_i.wr && port_select_index == 8'h03) |=> (wdt == $past(io_req_i.wdata)))
		else $error("watchdog control write lost");

	a_spm_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(hit_dat && io_req_i.wr && port_select_index == 8'h0A) |=> (spm[2] == $past(io_req_i.wdata)))
		else $error("soft power status write lost");

	a_smi_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(hit_dat && io_req_i.wr && port_select_index == 8'h0F) |=> (spm[7] == $past(io_req_i.wdata)))
		else $error("SMI status write lost");

	a_setup_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!cfg_req_i.mode |=> (port_pin_setup == $past(port_pin_setup)))
		else $error("pin setup changed outside configuration mode");

	a_input_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(hit_dat && io_req_i.wr && port_select_index == 8'h01)
			|=> (((bank[0] ^ $past(bank[0])) & $past(dir_in_vec[7:0])) == 8'h00))
		else $error("write changed an input bit");

	a_irq_or: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		##1 (combined_port_interrupt_o == $past(|cell_irq)))
		else $error("combined interrupt not the OR of enabled pins");

endmodule

`default_nettype wire

/* File: design/gidp_pkg.sv */
// Shared constants, register map and carrier types of the index/data port block.
package gidp_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_BANKS = 6;
	localparam int BANK_W    = 8;
	localparam int NUM_PINS  = NUM_BANKS * BANK_W;
	localparam int IO_ADDR_W = 10;
	localparam int SPM_REGS  = 8;

	// ----------------------------------------------------------------
	// Run-mode index codes
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_BANK1     = 8'h01;
	localparam logic [7:0] IDX_BANK2     = 8'h02;
	localparam logic [7:0] IDX_WDT       = 8'h03;
	localparam logic [7:0] IDX_BANK4     = 8'h04;
	localparam logic [7:0] IDX_BANK7     = 8'h07;
	localparam logic [7:0] IDX_SPM_FIRST = 8'h08;
	localparam logic [7:0] IDX_SMI_FIRST = 8'h0C;
	localparam logic [7:0] IDX_LAST      = 8'h0F;

	// ----------------------------------------------------------------
	// Configuration-space register numbers of logical device eight
	// ----------------------------------------------------------------
	localparam logic [7:0] CR_WDT       = 8'hF4;
	localparam logic [7:0] CR_BANK1     = 8'hF6;
	localparam logic [7:0] CR_BANK2     = 8'hF7;
	localparam logic [7:0] CR_BANK4     = 8'hF8;
	localparam logic [7:0] CR_BANK7     = 8'hFB;
	localparam logic [7:0] CR_SPM_FIRST = 8'hB0;
	localparam logic [7:0] CR_SPM_LAST  = 8'hB7;
	localparam logic [7:0] CR_PIN_FIRST = 8'h00;
	localparam logic [7:0] CR_PIN_LAST  = 8'h2F;
	localparam logic [7:0] CR_INDEX_SEL = 8'h30;
	localparam logic [7:0] CR_IRQ_CHAN  = 8'h31;

	// ----------------------------------------------------------------
	// Index register placement
	// ----------------------------------------------------------------
	localparam logic [IO_ADDR_W-1:0] ADDR_IDX_E0 = 10'h0E0;
	localparam logic [IO_ADDR_W-1:0] ADDR_IDX_E2 = 10'h0E2;
	localparam logic [IO_ADDR_W-1:0] ADDR_IDX_E4 = 10'h0E4;
	localparam logic [IO_ADDR_W-1:0] ADDR_IDX_EA = 10'h0EA;
	localparam logic [IO_ADDR_W-1:0] DATA_OFFSET = 10'h001;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] BASE_SEL_RST  = 2'h3;
	localparam logic [7:0] INDEX_RST     = 8'h00;
	localparam logic [7:0] BANK_RST      = 8'h00;
	localparam logic [7:0] WDT_RST       = 8'h00;
	localparam logic [7:0] SPM_RST       = 8'h00;
	localparam logic [7:0] PIN_CFG_RST   = 8'h01;
	localparam logic [3:0] IRQ_CHAN_RST  = 4'h0;

	// Pins whose alternate function is an input (ports 10, 11, 12, 21).
	localparam logic [NUM_PINS-1:0] ALT_IN_TYPE_MASK = 48'h0000_0000_0207;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_HZ  = 100_000_000;
	localparam int DBNC_TIME_MS = 1;
	localparam int DBNC_CYCLES  = CLK_FREQ_HZ / 1000 * DBNC_TIME_MS;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                 rd;
		logic                 wr;
		logic [IO_ADDR_W-1:0] addr;
		logic [7:0]           wdata;
	} gidp_io_req_t;

	typedef struct packed {
		logic       mode;
		logic       rd;
		logic       wr;
		logic [7:0] regno;
		logic [7:0] wdata;
	} gidp_cfg_req_t;

	typedef struct packed {
		logic       dbnc_en;
		logic [2:0] spare;
		logic       alt_sel;
		logic       irq_en;
		logic       invert;
		logic       dir_in;
	} gidp_pin_cfg_t;

endpackage

/* File: design/gidp_pin_cell.sv */
// One port pin: input synchroniser, debounce filter and mode steering.
`timescale 1ns/1ps
`default_nettype none

module gidp_pin_cell #(
	parameter int DBNC_CYCLES = gidp_pkg::DBNC_CYCLES,
	parameter int CNT_W       = $clog2(DBNC_CYCLES + 1),
	parameter bit ALT_IN_TYPE = 1'b0
) (
	// Clock and reset.
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	// Pin and setup.
	input  wire logic                   pin_i,
	input  wire gidp_pkg::gidp_pin_cfg_t cfg_i,
	input  wire logic                   data_bit_i,
	input  wire logic                   alt_out_i,
	// Results.
	output logic                        drive_o,
	output logic                        oe_n_o,
	output logic                        rd_bit_o,
	output logic                        alt_in_o,
	output logic                        irq_o
);

	logic             sync1;
	logic             sync2;
	logic             filt;
	logic [CNT_W-1:0] cnt;
	logic             next_sync1;
	logic             next_sync2;
	logic             next_filt;
	logic [CNT_W-1:0] next_cnt;
	logic             pin_val;
	logic             alt_valid;
	logic             in_src;

	// ----------------------------------------------------------------
	// Sampling and debounce
	// ----------------------------------------------------------------

	// The pin is sampled in every mode; the filter follows only after a long stable run.
	always_comb begin
		next_sync1 = pin_i;
		next_sync2 = sync1;
		next_filt  = filt;
		next_cnt   = '0;
		if (sync2 != filt) begin
			if (cnt == CNT_W'(DBNC_CYCLES)) begin
				next_filt = sync2;
			end else begin
				next_cnt = cnt + CNT_W'(1);
			end
		end
	end

	// Registers of the sampling path.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			filt  <= 1'b0;
			cnt   <= '0;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			filt  <= next_filt;
			cnt   <= next_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Mode steering
	// ----------------------------------------------------------------

	// Invalid alternate codes fall back to plain port operation.
	always_comb begin
		pin_val   = sync2 ^ cfg_i.invert;
		alt_valid = cfg_i.alt_sel && (ALT_IN_TYPE ? cfg_i.dir_in : !cfg_i.dir_in);
		oe_n_o    = cfg_i.dir_in;
		if (alt_valid && !ALT_IN_TYPE) begin
			drive_o = alt_out_i ^ cfg_i.invert;
		end else begin
			drive_o = data_bit_i ^ cfg_i.invert;
		end
		alt_in_o = alt_valid && ALT_IN_TYPE && pin_val;
		rd_bit_o = cfg_i.dir_in ? pin_val : data_bit_i;
		in_src   = cfg_i.dbnc_en ? (filt ^ cfg_i.invert) : pin_val;
		irq_o    = cfg_i.irq_en && (cfg_i.dir_in ? in_src : drive_o);
	end

	// The filtered level never moves before the full quiet count has run.
	a_dbnc_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(filt != $past(filt)) |-> ($past(cnt) == CNT_W'(DBNC_CYCLES)))
		else $error("debounce output changed early");

endmodule

`default_nettype wire

/* File: verification/gidp_pin_partner.sv */
// Pin-side partner: driven pins read back, undriven pins see the far-side level.
`timescale 1ns/1ps
`default_nettype none
module gidp_pin_partner #(
	parameter int N = gidp_pkg::NUM_PINS
) (
	// Block side and far side.
	input  wire logic [N-1:0] drive_i,
	input  wire logic [N-1:0] oe_n_i,
	input  wire logic [N-1:0] ext_i,
	output logic      [N-1:0] pin_o
);
	// Each pin takes the level of whichever party drives it.
	assign pin_o = (drive_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the index/data port block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH %0t bad value", $time); end end
module testbench;
	logic                  clk_i = 1'b0;
	logic                  sys_rst_i = 1'b1;
	gidp_pkg::gidp_io_req_t  io_req = '0;
	gidp_pkg::gidp_cfg_req_t cfg_req = '0;
	logic                  run_en = 1'b1;
	logic [47:0]           ext = '0;
	logic [47:0]           alt = '0;
	logic [47:0]           alt_in;
	logic                  cfg_rvalid;
	logic [47:0]           pin_in;
	logic [47:0]           pin_out;
	logic [47:0]           oe_n;
	logic [9:0]            base = 10'h0EA;
	logic [7:0]            io_rdata_o, cfg_rdata_o, wdt;
	logic                  io_rvalid_o, irq;
	logic [3:0]            chan;
	logic [7:0][7:0]       spm;
	int                    bad_count = 0;
	int                    num_checks = 0;
	// Clock of 100 MHz.
	always #5 clk_i = ~clk_i;
	gidp_top #(.DBNC_CYCLES(8)) i_gidp_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .io_req_i(io_req),
		.io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .cfg_req_i(cfg_req), .cfg_rdata_o(cfg_rdata_o),
		.cfg_rvalid_o(cfg_rvalid), .run_access_en_i(run_en), .pin_in_i(pin_in), .pin_out_o(pin_out),
		.pin_oe_n_o(oe_n), .alt_out_i(alt), .alt_in_o(alt_in), .combined_port_interrupt_o(irq),
		.combined_irq_channel_select_o(chan), .watchdog_control_reg_o(wdt), .spm_regs_o(spm));
	gidp_pin_partner i_gidp_pin_partner (.drive_i(pin_out), .oe_n_i(oe_n), .ext_i(ext), .pin_o(pin_in));
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One run-mode cycle and one idle cycle; on a read, d is the expected data.
	task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d);
		io_req = '{rd: !w, wr: w, addr: a, wdata: d};
		@(negedge clk_i);
		io_req = '0;
		if (!w) begin
			for (int i = 0; i < 3 && io_rvalid_o !== 1'b1; i++) @(negedge clk_i);
			`CHK(io_rvalid_o, 1'b1)
			if (io_rvalid_o !== 1'b1) stop_test();
			`CHK(io_rdata_o, d)
		end
		@(negedge clk_i);
	endtask
	// Index write followed by a data-port access.
	task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
		io(1'b1, base, idx);
		io(w, base + 10'h001, d);
	endtask
	// One configuration-mode cycle and one idle cycle; on a read, d is the expected data.
	task automatic cf(input logic w, input logic [7:0] r, input logic [7:0] d);
		cfg_req = '{mode: 1'b1, rd: !w, wr: w, regno: r, wdata: d};
		@(negedge clk_i);
		cfg_req = '0;
		if (!w) begin
			`CHK(cfg_rvalid, 1'b1)
			`CHK(cfg_rdata_o, d)
		end
		@(negedge clk_i);
	endtask
	// Main sequence, driven on falling edges.
	initial begin
		repeat (8) @(negedge clk_i);
		sys_rst_i = 1'b0;
		ext[7:0] = 8'h5A;
		repeat (4) @(negedge clk_i);
		acc(1'b1, 8'h01, 8'hFF);
		acc(1'b0, 8'h01, 8'h5A);
		$display("reset and input test done");
		for (int i = 0; i < 4; i++) cf(1'b1, i[7:0], (i == 3) ? 8'h02 : 8'h00);
		cf(1'b1, 8'h04, 8'h03);
		cf(1'b0, 8'h04, 8'h03);
		acc(1'b1, 8'h01, 8'hFF);
		repeat (4) @(negedge clk_i);
		`CHK(pin_out[3:0], 4'h7)
		`CHK(oe_n[4:0], 5'h10)
		acc(1'b0, 8'h01, 8'h4F);
		$display("output and polarity test done");
		cf(1'b1, 8'hF4, 8'h3C);
		acc(1'b0, 8'h03, 8'h3C);
		for (int k = 8; k < 16; k++) begin
			acc(1'b1, k[7:0], 8'(k * 3));
			`CHK(spm[k - 8], 8'(k * 3))
		end
		acc(1'b1, 8'h10, 8'hFF);
		acc(1'b0, 8'h10, 8'h00);
		acc(1'b0, 8'h00, 8'h00);
		$display("index map test done");
		run_en = 1'b0;
		acc(1'b1, 8'h03, 8'hFF);
		run_en = 1'b1;
		`CHK(wdt, 8'h3C)
		cf(1'b1, 8'h30, 8'h00);
		base = 10'h0E0;
		acc(1'b0, 8'h03, 8'h3C);
		$display("access gate and base test done");
		cf(1'b1, 8'h31, 8'h05);
		`CHK(chan, 4'h5)
		cf(1'b1, 8'h08, 8'h05);
		ext[8] = 1'b1;
		repeat (6) @(negedge clk_i);
		`CHK(irq, 1'b1)
		ext[8] = 1'b0;
		repeat (6) @(negedge clk_i);
		`CHK(irq, 1'b0)
		$display("interrupt test done");
		cf(1'b1, 8'h08, 8'h85);
		ext[8] = 1'b1;
		repeat (6) @(negedge clk_i);
		`CHK(irq, 1'b0)
		ext[8] = 1'b0;
		repeat (4) @(negedge clk_i);
		ext[8] = 1'b1;
		repeat (16) @(negedge clk_i);
		`CHK(irq, 1'b1)
		ext[8] = 1'b0;
		repeat (16) @(negedge clk_i);
		`CHK(irq, 1'b0)
		$display("debounce test done");
		cf(1'b1, 8'h00, 8'h0B);
		cf(1'b1, 8'h01, 8'h08);
		cf(1'b1, 8'h03, 8'h08);
		repeat (6) @(negedge clk_i);
		`CHK(alt_in[1:0], 2'h1)
		`CHK(pin_out[1], 1'b1)
		`CHK(pin_out[3], 1'b0)
		alt[3] = 1'b1;
		repeat (2) @(negedge clk_i);
		`CHK(pin_out[3], 1'b1)
		$display("alternate function test done");
		stop_test();
	end
endmodule
`default_nettype wire
